/* File: hdl/mcp_map.svh */
// Constants of the monitor and control point bank: point offsets, command codes,
// status encodings and timing. Included by the point bank only.
`ifndef MCP_MAP_SVH
`define MCP_MAP_SVH
// Point offsets
`define OFS_PRIMARY       8'h20
`define OFS_SECONDARY     8'h21
`define OFS_LIVE_BASE     8'h22
`define OFS_SNAP_BASE     8'h32
`define OFS_WR_BASE       8'h40
`define OFS_WR_LAST       8'h5F
`define OFS_LIMIT_BASE    8'h42
`define OFS_TUNE_BASE     8'h50
`define OFS_CAL_BASE      8'h56
`define OFS_SERIAL        8'h60
`define OFS_VERSION       8'h62
`define OFS_CRC           8'h64
`define OFS_CHECK         8'h67
// Parameter RAM indices relative to the command point
`define IDX_CMD           5'h00
`define IDX_FIRST_PARAM   5'h02
`define PARAM_BYTES       5'h1E
// Command codes and answers
`define CMD_DONE          8'h00
`define CMD_RESEND_TUNE   8'h01
`define CMD_CAL_ZERO0     8'h02
`define CMD_CAL_ONE0      8'h05
`define CMD_CAL_ONE2      8'h07
`define CMD_RELOAD        8'h08
`define CMD_SAVE          8'h09
`define CMD_PSU_OFF       8'h10
`define CMD_PSU_ON        8'h11
`define CMD_FAULT_ON      8'h12
`define CMD_FAULT_OFF     8'h13
`define CMD_LED_OFF       8'h14
`define CMD_LED_ON        8'h15
`define CMD_CRC           8'h16
`define CMD_BUSY_STEP     8'h08
`define CMD_TOO_HIGH      8'hFF
`define CMD_TOO_LOW       8'hFE
`define CMD_UNKNOWN       8'hFF
// Shutdown causes set by a host command
`define PSU_CAUSE_HOST    4'h8
`define AMP_CAUSE_HOST    4'h5
// Timing: one reading update takes this long
`define CLK_MHZ           125
`define UPDATE_NS         1000
// Numeric constants of the readings and codes
`define CRC_INIT          16'hFFFF
`define CRC_POLY          16'h1021
`define LIMIT_SHIFT       2
`define OPT_LIMIT_SHIFT   8
`endif

/* File: hdl/mcp_pkg.sv */
// Types shared by the monitor and control point bank.
// Assumes the constants header is included where offsets are needed.
package mcp_pkg;
	typedef logic [7:0]  point_byte_t;
	typedef logic [11:0] reading_t;
	typedef logic [11:0] dac_code_t;
	typedef logic [3:0]  cause_t;
	typedef enum logic [2:0] {
		ST_LOAD  = 3'b000,
		ST_CRC   = 3'b001,
		ST_IDLE  = 3'b010,
		ST_SAVE  = 3'b011,
		ST_CAL   = 3'b100
	} seq_state_t;
endpackage

/* File: hdl/monitor_control_point_bank.sv */
// Monitor and control point bank: 256 byte points read and written by the
// serial bus interface, live readings, limits, calibration, status and CRC.
// Assumes all inputs come from logic on i_ref_clk; code memory answers in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mcp_map.svh"

// How it works
// - 256 points, 69 defined, 32 writable
// - writes to live readings silently dropped
// - negative supply ten-bit code, two bytes
// - 3.3 V supply ten-bit code, two bytes
// - eight-volt supply ten-bit code, two bytes
// - temperature ten-bit code, two bytes
// - optical readings twelve-bit code, two bytes
// - top bit flags reading under update
// - limits load from EEPROM, writes hit RAM
// - supply limit byte times four compared
// - optical upper times 256, lower eight-bit
// - zero and one-milliwatt calibration points writable
// - fine tune reaches converter at start-up and on resend-tune command
// - primary status bits 7..4 fault flags
// - primary bits 3..0 last restart cause
// - secondary low nibble supply shutdown cause
// - secondary high nibble amplifier shutdown cause
// - shutdown freezes snapshots of all readings
// - board identity: revision nibble, twelve-bit serial
// - save stores checksum, reload checks it
// - CRC-16 over program words at startup
// - command point cleared on success, high on failure
// - writes outside writable set dropped quietly
module monitor_control_point_bank #(
	parameter int          CRC_WORDS   = 2048,
	parameter int          CAL_SAMPLES = 256,
	parameter logic [15:0] SW_VERSION  = 16'h0100   // Arbitrary value
) (
	// Clock and reset
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst_n,
	// Point access from the serial bus interface
	input  wire logic                   i_wr_en,
	input  wire logic                   i_rd_en,
	input  wire logic [7:0]             i_addr,
	input  wire mcp_pkg::point_byte_t   i_wdata,
	output logic       [7:0]            o_rdata,
	// Measurements from the converter sequencer
	input  wire logic                   i_meas_valid,
	input  wire logic [2:0]             i_meas_sel,
	input  wire mcp_pkg::reading_t      i_meas_code,
	output logic                        o_meas_ready,
	// Shutdown events from the supervisor
	input  wire logic                   i_psu_trip,
	input  wire mcp_pkg::cause_t        i_psu_trip_cause,
	input  wire logic                   i_amp_trip,
	input  wire mcp_pkg::cause_t        i_amp_trip_cause,
	// Start-up information
	input  wire mcp_pkg::cause_t        i_restart_cause,
	input  wire logic [15:0]            i_board_id,
	input  wire logic                   i_board_id_bad,
	// Program code memory read port
	output logic       [10:0]           o_code_addr,
	input  wire logic [13:0]            i_code_word,
	// Controls driven by the bank
	output mcp_pkg::dac_code_t [2:0]    o_fine_tune,
	output logic                        o_psu_enable,
	output logic                        o_opt_fault,
	output logic                        o_led_enable,
	output logic       [6:0]            o_limit_alarm,
	output logic                        o_ready
);
	import mcp_pkg::*;

	localparam int UPDATE_CYC = (`UPDATE_NS * `CLK_MHZ + 999) / 1000;
	localparam int NREAD      = 7;

	generate
		if (CRC_WORDS < 1 || CRC_WORDS > 2048 || CAL_SAMPLES != 256) begin : g_bad
			$error("Unsupported CRC_WORDS or CAL_SAMPLES");
		end
	endgenerate

	seq_state_t        state;
	point_byte_t       param [32];        // Points 0x40..0x5F
	point_byte_t       eep [30];          // Non-volatile copy of the parameters
	point_byte_t       eep_sum;
	reading_t          live [NREAD];
	reading_t          snap [NREAD];
	logic [NREAD-1:0]  live_busy;
	logic [7:0]        upd_cnt;
	logic [2:0]        upd_sel;
	reading_t          upd_code;
	logic [4:0]        idx;
	point_byte_t       sum;
	point_byte_t       syndrome;
	logic              ck_fail;
	logic [11:0]       crc_cnt;
	logic [15:0]       crc;
	logic [15:0]       crc_result;
	logic [19:0]       cal_acc;
	logic [8:0]        cal_cnt;
	logic [2:0]        cal_rx;
	logic              cal_one;
	logic              started;
	cause_t            restart;
	logic [15:0]       board_id;
	logic              id_bad;
	cause_t            psu_cause;
	cause_t            amp_cause;
	logic              host_wr;
	logic              sample_take;
	logic [11:0]       cal_avg;
	point_byte_t       cmd;

	// Reading width mask: optical twelve bits, supplies and temperature ten
	// ten-bit readings masked
	function automatic reading_t fit(input logic [2:0] sel, input reading_t code);
		return (sel < 3'd3) ? code : {2'b00, code[9:0]};
	endfunction

	// One 16-bit word through CRC-16, x16+x12+x5+1, MSB first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
		logic [15:0] r;
		r = c;
		for (int b = 15; b >= 0; b--) begin
			r = (r[15] ^ w[b]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// Twelve-bit value held in a two-byte point pair
	function automatic logic [11:0] pair12(input point_byte_t ms, input point_byte_t ls);
		return {ms[3:0], ls};
	endfunction

	assign host_wr      = i_wr_en && i_addr >= `OFS_WR_BASE && i_addr <= `OFS_WR_LAST;
	assign sample_take  = i_meas_valid && o_meas_ready && i_meas_sel < 3'(NREAD);
	assign o_meas_ready = (upd_cnt == 8'h00);
	assign o_ready      = (state == ST_IDLE);
	assign cmd          = param[`IDX_CMD];
	assign cal_avg      = cal_acc[19:8];

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			upd_cnt   <= 8'h00;
			upd_sel   <= 3'h0;
			upd_code  <= 12'h000;
			live_busy <= '0;
		end else if (sample_take) begin
			upd_cnt   <= 8'(UPDATE_CYC);
			upd_sel   <= i_meas_sel;
			upd_code  <= fit(i_meas_sel, i_meas_code);
			live_busy <= 7'(1) << i_meas_sel;
		end else if (upd_cnt != 8'h00) begin
			upd_cnt <= upd_cnt - 8'h01;
			if (upd_cnt == 8'h01) begin
				live_busy <= '0;
			end
		end
	end

	// live readings commit at window end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NREAD; i++) begin
				live[i] <= 12'h000;
			end
		end else if (upd_cnt == 8'h01) begin
			live[upd_sel] <= upd_code;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NREAD; i++) begin
				snap[i] <= 12'h000;
			end
		end else if (i_psu_trip || i_amp_trip) begin
			for (int i = 0; i < NREAD; i++) begin
				snap[i] <= live[i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NREAD; g++) begin : g_alarm
			logic [11:0] up;
			logic [11:0] lo;
			if (g < 3) begin : g_opt
				assign up = {param[2 + 2*g][3:0], 8'h00};
				assign lo = {4'h0, param[3 + 2*g]};
			end else begin : g_sup
				assign up = {2'b00, param[2 + 2*g], 2'b00};
				assign lo = {2'b00, param[3 + 2*g], 2'b00};
			end
			assign o_limit_alarm[g] = (state != ST_LOAD) && (live[g] > up || live[g] < lo);
		end
	endgenerate

	// Start-up capture of restart cause and board identity
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			started  <= 1'b0;
			restart  <= 4'h0;
			board_id <= 16'h0000;
			id_bad   <= 1'b0;
		end else if (!started) begin
			started  <= 1'b1;
			restart  <= i_restart_cause;
			board_id <= i_board_id;
			id_bad   <= i_board_id_bad;
		end
	end

	// Sequencer: EEPROM load and save, CRC, calibration
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state   <= ST_LOAD;
			idx     <= 5'h00;
			sum     <= 8'h00;
			crc_cnt <= 12'h000;
			crc     <= `CRC_INIT;
			cal_acc <= 20'h00000;
			cal_cnt <= 9'h000;
		end else begin
			unique case (state)
				ST_LOAD: begin
					sum <= sum + eep[idx];
					idx <= idx + 5'h01;
					if (idx == `PARAM_BYTES - 5'h01) begin
						idx   <= 5'h00;
						// CRC result kept: a reload must not wipe it
						state <= started && crc_cnt == 12'hFFF ? ST_IDLE : ST_CRC;
					end
				end
				ST_SAVE: begin
					sum <= sum + param[idx + `IDX_FIRST_PARAM];
					idx <= idx + 5'h01;
					if (idx == `PARAM_BYTES - 5'h01) begin
						idx   <= 5'h00;
						state <= ST_IDLE;
					end
				end
				ST_CRC: begin
					crc_cnt <= crc_cnt + 12'h001;
					if (crc_cnt != 12'h000) begin
						crc <= crc_step(crc, {2'b00, i_code_word});
					end
					if (crc_cnt == 12'(CRC_WORDS)) begin
						crc_cnt <= 12'hFFF;
						state   <= ST_IDLE;
					end
				end
				ST_CAL: begin
					if (sample_take && i_meas_sel == cal_rx) begin
						cal_acc <= cal_acc + 20'(fit(i_meas_sel, i_meas_code));
						cal_cnt <= cal_cnt + 9'h001;
					end
					if (cal_cnt == 9'(CAL_SAMPLES)) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					sum     <= 8'h00;
					cal_acc <= 20'h00000;
					cal_cnt <= 9'h000;
					if (host_wr && i_addr == `OFS_WR_BASE && cmd == `CMD_DONE) begin
						if (i_wdata == `CMD_RELOAD) begin
							state <= ST_LOAD;
						end else if (i_wdata == `CMD_SAVE) begin
							state <= ST_SAVE;
						end else if (i_wdata == `CMD_CRC) begin
							crc     <= `CRC_INIT;
							crc_cnt <= 12'h000;
							state   <= ST_CRC;
						end else if (i_wdata >= `CMD_CAL_ZERO0 && i_wdata <= `CMD_CAL_ONE2) begin
							state <= ST_CAL;
						end
					end
				end
			endcase
		end
	end
	assign o_code_addr = crc_cnt[10:0];
	assign crc_result  = crc;

	// Calibration target latched on every idle write of the command point
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cal_rx  <= 3'h0;
			cal_one <= 1'b0;
		end else if (state == ST_IDLE && host_wr && i_addr == `OFS_WR_BASE) begin
			cal_one <= (i_wdata >= `CMD_CAL_ONE0);
			cal_rx  <= (i_wdata >= `CMD_CAL_ONE0) ? 3'(i_wdata - `CMD_CAL_ONE0)
			                                      : 3'(i_wdata - `CMD_CAL_ZERO0);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 30; i++) begin
				eep[i] <= 8'h00;
			end
			eep_sum <= 8'h00;
		end else if (state == ST_SAVE) begin
			eep[idx] <= param[idx + `IDX_FIRST_PARAM];
			if (idx == `PARAM_BYTES - 5'h01) begin
				eep_sum <= sum + param[idx + `IDX_FIRST_PARAM];
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ck_fail  <= 1'b0;
			syndrome <= 8'h00;
		end else if (state == ST_LOAD && idx == `PARAM_BYTES - 5'h01) begin
			syndrome <= (sum + eep[idx]) ^ eep_sum;
			ck_fail  <= ((sum + eep[idx]) != eep_sum);
		end
	end

	// Parameter RAM and command point
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 32; i++) begin
				param[i] <= 8'h00;
			end
		end else begin
			if (state == ST_LOAD) begin
				param[idx + `IDX_FIRST_PARAM] <= eep[idx];
			end else if (state == ST_CAL && cal_cnt == 9'(CAL_SAMPLES)) begin
				if (!cal_one && cal_avg > 12'h0FF) begin
					param[`IDX_CMD] <= `CMD_TOO_HIGH;
				end else if (!cal_one) begin
					param[5'h18 + 5'(3*cal_rx)] <= cal_avg[7:0];
					param[`IDX_CMD] <= `CMD_DONE;
				end else if (cal_avg <= {4'h0, param[5'h18 + 5'(3*cal_rx)]}) begin
					param[`IDX_CMD] <= `CMD_TOO_LOW;
				end else begin
					param[5'h16 + 5'(3*cal_rx)] <= {4'h0, cal_avg[11:8]};
					param[5'h17 + 5'(3*cal_rx)] <= cal_avg[7:0];
					param[`IDX_CMD] <= `CMD_DONE;
				end
			end else if ((state == ST_SAVE || state == ST_CRC) && state != ST_IDLE &&
			             (idx == `PARAM_BYTES - 5'h01 || crc_cnt == 12'(CRC_WORDS))) begin
				param[`IDX_CMD] <= `CMD_DONE;
			end else if (host_wr && i_addr == `OFS_WR_BASE) begin
				// command accepted or refused
				// A failure code is cleared by writing zero
				if ((cmd != `CMD_DONE || state != ST_IDLE) &&
				    !(cmd >= `CMD_TOO_LOW && i_wdata == `CMD_DONE)) begin
					param[`IDX_CMD] <= cmd;
				end else if (i_wdata >= `CMD_CAL_ZERO0 && i_wdata <= `CMD_CAL_ONE2) begin
					param[`IDX_CMD] <= i_wdata + `CMD_BUSY_STEP;
				end else if (i_wdata == `CMD_RELOAD || i_wdata == `CMD_SAVE ||
				             i_wdata == `CMD_CRC) begin
					param[`IDX_CMD] <= i_wdata;
				end else if (i_wdata == `CMD_DONE || i_wdata == `CMD_RESEND_TUNE ||
				             (i_wdata >= `CMD_PSU_OFF && i_wdata <= `CMD_LED_ON)) begin
					param[`IDX_CMD] <= `CMD_DONE;
				end else begin
					param[`IDX_CMD] <= `CMD_UNKNOWN;
				end
			end else if (host_wr && state != ST_LOAD) begin
				// limits, calibration and tune RAM writes
				param[5'(i_addr - `OFS_WR_BASE)] <= i_wdata;
			end
			if (state == ST_LOAD && idx == `PARAM_BYTES - 5'h01 && started &&
			    crc_cnt == 12'hFFF) begin
				param[`IDX_CMD] <= `CMD_DONE;
			end
		end
	end

	// fine tune reaches converter on command
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fine_tune <= '0;
		end else if ((state == ST_LOAD && idx == `PARAM_BYTES - 5'h01 && !started) ||
		             (state == ST_CRC && crc_cnt == 12'(CRC_WORDS) && cmd == `CMD_DONE) ||
		             (state == ST_IDLE && host_wr && i_addr == `OFS_WR_BASE &&
		              cmd == `CMD_DONE && i_wdata == `CMD_RESEND_TUNE)) begin
			for (int r = 0; r < 3; r++) begin
				o_fine_tune[r] <= pair12(param[16 + 2*r], param[17 + 2*r]);
			end
		end
	end

	// Supply, fault line and display controls with shutdown causes
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_psu_enable <= 1'b0;
			o_opt_fault  <= 1'b0;
			o_led_enable <= 1'b1;
			psu_cause    <= 4'h0;
			amp_cause    <= 4'h0;
		end else begin
			if (state == ST_IDLE && host_wr && i_addr == `OFS_WR_BASE && cmd == `CMD_DONE) begin
				unique case (i_wdata)
					`CMD_PSU_OFF: begin
						o_psu_enable <= 1'b0;
						psu_cause    <= `PSU_CAUSE_HOST;
					end
					`CMD_PSU_ON:    o_psu_enable <= 1'b1;
					`CMD_FAULT_ON: begin
						o_opt_fault <= 1'b1;
						amp_cause   <= `AMP_CAUSE_HOST;
					end
					`CMD_FAULT_OFF: o_opt_fault  <= 1'b0;
					`CMD_LED_OFF:   o_led_enable <= 1'b0;
					`CMD_LED_ON:    o_led_enable <= 1'b1;
					default:        o_led_enable <= o_led_enable;
				endcase
			end
			if (i_psu_trip) begin
				o_psu_enable <= 1'b0;
				psu_cause    <= i_psu_trip_cause;
			end
			if (i_amp_trip) begin
				o_opt_fault <= 1'b1;
				amp_cause   <= i_amp_trip_cause;
			end
		end
	end

	// Point read mux, registered one cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd_en) begin
			o_rdata <= 8'h00;
			// defined points decode, rest read zero
			if (i_addr == `OFS_PRIMARY) begin
				o_rdata <= {o_opt_fault, !o_psu_enable, id_bad, ck_fail, restart};
			end else if (i_addr == `OFS_SECONDARY) begin
				o_rdata <= {amp_cause, psu_cause};
			end else if (i_addr >= `OFS_LIVE_BASE && i_addr < `OFS_LIVE_BASE + 8'd14) begin
				o_rdata <= i_addr[0] ? live[3'((i_addr - `OFS_LIVE_BASE) >> 1)][7:0]
				         : {live_busy[3'((i_addr - `OFS_LIVE_BASE) >> 1)], 3'b000,
				            live[3'((i_addr - `OFS_LIVE_BASE) >> 1)][11:8]};
			end else if (i_addr >= `OFS_SNAP_BASE && i_addr < `OFS_SNAP_BASE + 8'd14) begin
				o_rdata <= i_addr[0] ? snap[3'((i_addr - `OFS_SNAP_BASE) >> 1)][7:0]
				         : {4'h0, snap[3'((i_addr - `OFS_SNAP_BASE) >> 1)][11:8]};
			end else if (i_addr >= `OFS_WR_BASE && i_addr <= `OFS_WR_LAST) begin
				o_rdata <= param[5'(i_addr - `OFS_WR_BASE)];
			end else if (i_addr == `OFS_SERIAL || i_addr == `OFS_SERIAL + 8'd1) begin
				o_rdata <= i_addr[0] ? board_id[7:0] : board_id[15:8];
			end else if (i_addr == `OFS_VERSION || i_addr == `OFS_VERSION + 8'd1) begin
				o_rdata <= i_addr[0] ? SW_VERSION[7:0] : SW_VERSION[15:8];
			end else if (i_addr == `OFS_CRC || i_addr == `OFS_CRC + 8'd1) begin
				o_rdata <= i_addr[0] ? crc_result[7:0] : crc_result[15:8];
			end else if (i_addr == `OFS_CHECK) begin
				o_rdata <= syndrome;
			end
		end
	end
	// live, snapshot and status points have no write path
endmodule
`default_nettype wire

/* File: sim/mcp_bank_sva.sv */
// Port checker for the monitor and control point bank.
// Bound to the bank; one clock domain, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mcp_bank_sva (
	// Clock and reset
	input wire logic                     i_ref_clk,
	input wire logic                     i_rst_n,
	// Point bus
	input wire logic                     i_wr_en,
	input wire logic                     i_rd_en,
	input wire logic [7:0]               i_addr,
	input wire mcp_pkg::point_byte_t     i_wdata,
	input wire logic [7:0]               o_rdata,
	// Measurements, events and controls
	input wire logic                     i_meas_valid,
	input wire logic [2:0]               i_meas_sel,
	input wire logic                     o_meas_ready,
	input wire logic                     i_psu_trip,
	input wire logic                     i_amp_trip,
	input wire mcp_pkg::dac_code_t [2:0] o_fine_tune,
	input wire logic                     o_psu_enable,
	input wire logic                     o_opt_fault,
	input wire logic                     o_led_enable,
	input wire logic                     o_ready
);
	import mcp_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Host write to the command point
	wire logic cmd_wr = i_wr_en && i_addr == 8'h40;
	wire logic take = i_meas_valid && o_meas_ready && i_meas_sel != 3'h7;

	a_meas_busy_window: assert property (
		take |=> !o_meas_ready [*8] ##117 !o_meas_ready ##1 o_meas_ready)
		else $error("update window length wrong");
	a_rdata_holds: assert property (
		!i_rd_en |=> $stable(o_rdata))
		else $error("read data moved without a read");
	a_status_flags: assert property (
		(i_rd_en && i_addr == 8'h20) |=>
		o_rdata[7:6] == {$past(o_opt_fault), !$past(o_psu_enable)})
		else $error("status flags disagree with outputs");
	a_fault_cause: assert property (
		$rose(o_opt_fault) |-> $past(i_amp_trip || (cmd_wr && i_wdata == 8'h12)))
		else $error("fault line rose without cause");
	a_psu_on_cause: assert property (
		$rose(o_psu_enable) |-> $past(cmd_wr && i_wdata == 8'h11))
		else $error("supplies on without command");
	a_psu_off_cause: assert property (
		$fell(o_psu_enable) |-> $past(i_psu_trip || (cmd_wr && i_wdata == 8'h10)))
		else $error("supplies off without cause");
	a_led_cause: assert property (
		$changed(o_led_enable) |-> $past(cmd_wr && i_wdata[7:1] == 7'h0A))
		else $error("display enable moved without command");
	a_tune_reload: assert property (
		$changed(o_fine_tune) |-> !$past(o_ready) || $past(cmd_wr && i_wdata == 8'h01)
		|| $past(cmd_wr && i_wdata == 8'h01, 2))
		else $error("fine tune moved without reload");
	// Main scenarios reached
	c_take: cover property (take);
	c_psu_on: cover property ($rose(o_psu_enable));
	c_fault: cover property ($rose(o_opt_fault));
endmodule
bind monitor_control_point_bank mcp_bank_sva mcp_bank_sva_inst (.i_ref_clk, .i_rst_n,
	.i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .i_meas_valid, .i_meas_sel,
	.o_meas_ready, .i_psu_trip, .i_amp_trip, .o_fine_tune, .o_psu_enable, .o_opt_fault,
	.o_led_enable, .o_ready);
`default_nettype wire

/* File: sim/host_link_model.sv */
// Model of the serial bus interface that relays the control computer.
// Drives the point bus on falling edges; one pulse per byte.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// Clock and answers from the bank
	input  wire logic       i_ref_clk,
	input  wire logic       i_ready,
	input  wire logic [7:0] i_rdata,
	// Point bus towards the bank
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata
);
	// Bus idle at time zero
	initial begin
		{o_wr_en, o_rd_en, o_addr, o_wdata} = 18'h0;
	end
	// Release: strobes low, lines stop showing the last value
	task automatic idle();
		{o_wr_en, o_rd_en} = 2'b00;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		{o_addr, o_wdata, o_wr_en} = {a, d, 1'b1};
		@(negedge i_ref_clk);
		idle();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		{o_addr, o_rd_en} = {a, 1'b1};
		@(negedge i_ref_clk);
		idle();
		d = i_rdata;
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		v = 16'h8000;
		for (int n = 0; n < 100 && v[15] !== 1'b0; n++) begin
			rd(a, v[15:8]);
			rd(a + 8'h01, v[7:0]);
		end
	endtask
	task automatic cmd(input logic [7:0] c, output logic [7:0] r);
		for (int n = 0; n < 3000 && i_ready !== 1'b1; n++) @(negedge i_ref_clk);
		wr(8'h40, c);
		r = c;
		for (int n = 0; n < 200 && r !== 8'h00 && r[7] !== 1'b1; n++) rd(8'h40, r);
	endtask
endmodule
`default_nettype wire

/* File: sim/monitor_control_point_bank_tb.sv */
// Self-checking bench for the point bank: point accesses, readings, trips, commands.
// Assumes the host model, checker and package are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module monitor_control_point_bank_tb;
	import mcp_pkg::*;
	logic            i_ref_clk, i_rst_n, i_wr_en, i_rd_en, i_meas_valid, o_meas_ready;
	logic            i_psu_trip, i_amp_trip, i_board_id_bad, o_psu_enable, o_opt_fault;
	logic            o_led_enable, o_ready;
	logic [7:0]      i_addr, o_rdata, b;
	point_byte_t     i_wdata;
	logic [2:0]      i_meas_sel;
	reading_t        i_meas_code;
	cause_t          i_psu_trip_cause, i_amp_trip_cause, i_restart_cause;
	logic [15:0]     i_board_id, w;
	logic [10:0]     o_code_addr, code_q;
	logic [13:0]     i_code_word;
	dac_code_t [2:0] o_fine_tune;
	logic [6:0]      o_limit_alarm;
	int              checks, fails;
	// Command code and expected {display, fault line, supplies}
	localparam logic [10:0] CMDS [6] = '{{8'h13, 3'b100}, {8'h11, 3'b101},
		{8'h10, 3'b100}, {8'h14, 3'b000}, {8'h15, 3'b100}, {8'h12, 3'b110}};

	monitor_control_point_bank #(.CRC_WORDS(4)) monitor_control_point_bank_inst (.i_ref_clk,
		.i_rst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .i_meas_valid,
		.i_meas_sel, .i_meas_code, .o_meas_ready, .i_psu_trip, .i_psu_trip_cause,
		.i_amp_trip, .i_amp_trip_cause, .i_restart_cause, .i_board_id, .i_board_id_bad,
		.o_code_addr, .i_code_word, .o_fine_tune, .o_psu_enable, .o_opt_fault,
		.o_led_enable, .o_limit_alarm, .o_ready);
	host_link_model host (.i_ref_clk, .i_ready(o_ready), .i_rdata(o_rdata),
		.o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));

	// 125 MHz clock
	initial i_ref_clk = 1'b0;
	always #4 i_ref_clk = ~i_ref_clk;
	// Program memory: erased pattern mixed with the address of the edge before
	always @(negedge i_ref_clk) begin
		i_code_word <= 14'h3FFF ^ {3'h0, code_q};
		code_q      <= o_code_addr;
	end
	// Expected CRC over the four words of the short program
	function automatic logic [15:0] crc_exp();
		logic [15:0] c;
		logic [15:0] d;
		c = 16'hFFFF;
		for (int a = 0; a < 4; a++) begin
			d = {2'h0, 14'h3FFF ^ 14'(a)};
			for (int k = 15; k >= 0; k--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic meas(input logic [2:0] s, input reading_t c);
		@(negedge i_ref_clk);
		{i_meas_sel, i_meas_code, i_meas_valid} = {s, c, 1'b1};
		@(negedge i_ref_clk);
		{i_meas_code, i_meas_valid} = {~c, 1'b0};
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#320000;
		fails++;
		results();
	end
	// Main sequence
	initial begin
		{i_rst_n, i_meas_valid, i_psu_trip, i_amp_trip, i_board_id_bad} = 5'h0;
		{i_meas_sel, i_meas_code, i_psu_trip_cause, i_amp_trip_cause} = 23'h0;
		{i_restart_cause, i_board_id} = {4'h2, 16'h5A3C};
		repeat (16) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		for (int n = 0; n < 3000 && o_ready !== 1'b1; n++) @(negedge i_ref_clk);
		host.rd(8'h20, b);
		chk(b, 8'h42);
		host.rd(8'h21, b);
		chk(b, 8'h00);
		host.rd16(8'h60, w);
		chk(w, 16'h5A3C);
		host.rd16(8'h64, w);
		chk(w, crc_exp());
		host.rd(8'h67, b);
		chk(b, 8'h00);
		// Readings of both widths, flagged while updating
		for (int s = 0; s < 5; s++) begin
			meas(s[2:0], 12'hABC);
			host.rd(8'h22 + 8'(2 * s), b);
			chk(b[7], 1'b1);
			repeat (130) @(negedge i_ref_clk);
			host.rd16(8'h22 + 8'(2 * s), w);
			chk(w, s < 3 ? 16'h0ABC : 16'h02BC);
		end
		host.wr(8'h22, 8'h55);
		host.wr(8'h60, 8'hAA);
		host.rd(8'h22, b);
		chk(b, 8'h0A);
		host.rd(8'h60, b);
		chk(b, 8'h5A);
		// Limits just either side of the readings
		host.wr(8'h48, 8'hAE);
		host.wr(8'h42, 8'h0A);
		host.rd(8'h48, b);
		chk(b, 8'hAE);
		chk({o_limit_alarm[3], o_limit_alarm[0]}, 2'b11);
		host.wr(8'h48, 8'hB0);
		host.wr(8'h42, 8'h0B);
		chk({o_limit_alarm[3], o_limit_alarm[0]}, 2'b00);
		// Both shutdowns in one cycle
		@(negedge i_ref_clk);
		{i_psu_trip, i_amp_trip, i_psu_trip_cause, i_amp_trip_cause} = 10'h356;
		@(negedge i_ref_clk);
		{i_psu_trip, i_amp_trip, i_psu_trip_cause, i_amp_trip_cause} = 10'h0A9;
		host.rd(8'h21, b);
		chk(b, 8'h65);
		host.rd(8'h20, b);
		chk(b, 8'hC2);
		host.rd16(8'h38, w);
		chk(w, 16'h02BC);
		host.rd16(8'h32, w);
		chk(w, 16'h0ABC);
		// Simple commands and their outputs
		for (int i = 0; i < 6; i++) begin
			host.cmd(CMDS[i][10:3], b);
			chk({b, 5'h0, o_led_enable, o_opt_fault, o_psu_enable}, {8'h0, 5'h0, CMDS[i][2:0]});
		end
		host.rd(8'h21, b);
		chk(b, 8'h58);
		host.cmd(8'h0A, b);
		chk(b, 8'hFF);
		host.cmd(8'h00, b);
		host.rd(8'h40, b);
		chk(b, 8'h00);
		host.cmd(8'h16, b);
		host.rd16(8'h64, w);
		chk({b, w}, {8'h00, crc_exp()});
		// Fine tune reaches the converter on the resend-tune command, not on a RAM write
		host.wr(8'h50, 8'h01);
		host.wr(8'h51, 8'h23);
		chk(o_fine_tune[0], 12'h000);
		host.cmd(8'h01, b);
		chk(o_fine_tune[0], 12'h123);
		// Save, spoil, reload
		host.wr(8'h43, 8'h55);
		host.cmd(8'h09, b);
		host.wr(8'h43, 8'h11);
		host.cmd(8'h08, b);
		host.rd(8'h43, b);
		chk(b, 8'h55);
		host.rd(8'h20, b);
		chk(b[4], 1'b0);
		host.rd16(8'h64, w);
		chk(w, crc_exp());
		results();
	end
endmodule
`default_nettype wire
